/* File: src/vchl_regs.sv */
// channel capability and header log register bank on AHB-Lite
`timescale 1ns/100ps
module vchl_regs (
    // clock and resets
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         por_n,
    // ahb-lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic      [31:0]  hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // strap pin and configuration autoload
    input  wire logic         second_channel_strap,
    input  wire logic         autoload_valid,
    input  wire logic [2:0]   autoload_ext_count,
    input  wire logic [2:0]   autoload_lp_count,
    // error events
    input  wire logic         err_valid,
    input  wire logic         err_masked,
    input  wire logic [127:0] err_header,
    output logic              err_report,
    // arbiter hand-off
    output logic              arb_load,
    output logic      [2:0]   arb_scheme,
    output logic      [127:0] arb_table,
    output logic              arb_table_dirty,
    input  wire logic         arb_load_done,
    // interrupt
    output logic              irq
);

    localparam int TW = vchl_pkg::TBL_WORDS;

    vchl_pkg::vchl_bus_state_type bus_r;
    vchl_pkg::vchl_bus_state_type bus_nxt;

    // bus front end
    logic [11:0]  addr_r;
    logic [31:0]  hrdata_r;
    logic         hready_r;
    logic         hresp_r;

    // capability counts and strap
    logic [2:0]   ext_cnt_r;
    logic [2:0]   ext_cnt_nxt;
    logic [2:0]   lp_cnt_r;
    logic [2:0]   lp_cnt_nxt;
    logic         strap_s1_r;
    logic         strap_s2_r;
    logic [1:0]   strap_cnt_r;
    logic         strap_done_r;

    // arbitration control and table
    logic [2:0]   sel_r;
    logic [2:0]   sel_nxt;
    logic         load_r;
    logic         load_pend_r;
    logic         load_pend_nxt;
    logic         tbl_stat_r;
    logic         tbl_stat_nxt;
    logic [31:0]  tbl_r [TW];
    logic [31:0]  ctrl_word;

    // interrupt
    logic [1:0]   irq_stat_r;
    logic [1:0]   irq_stat_nxt;
    logic [1:0]   irq_mask_r;
    logic         irq_r;
    logic [1:0]   irq_ev;

    // header log from the capture block
    logic [127:0] hdr_log;
    logic         hdr_captured;

    // address phase
    wire          req     = hsel & htrans[1] & hready;
    wire          wr_data = (bus_r == vchl_pkg::BUS_WRITE);
    wire          rd_fill = (bus_r == vchl_pkg::BUS_READ);

    // decode on the latched address
    wire          sel_hdr0 = addr_r == vchl_pkg::ADDR_HDR0;
    wire          sel_hdr1 = addr_r == vchl_pkg::ADDR_HDR1;
    wire          sel_hdr2 = addr_r == vchl_pkg::ADDR_HDR2;
    wire          sel_hdr3 = addr_r == vchl_pkg::ADDR_HDR3;
    wire          sel_caph = addr_r == vchl_pkg::ADDR_CAPHDR;
    wire          sel_cap1 = addr_r == vchl_pkg::ADDR_CAP1;
    wire          sel_cap2 = addr_r == vchl_pkg::ADDR_CAP2;
    wire          sel_ctrl = addr_r == vchl_pkg::ADDR_CTRL;
    wire          sel_ista = addr_r == vchl_pkg::ADDR_IRQ_STAT;
    wire          sel_imsk = addr_r == vchl_pkg::ADDR_IRQ_MASK;
    // the table exists only while the offset field points at it
    wire          tbl_on   = ext_cnt_r[0];
    wire          sel_tbl  = tbl_on &
                  (addr_r[11:4] == vchl_pkg::ADDR_TBL[11:4]);
    wire [1:0]    tbl_idx  = addr_r[3:2];

    wire          wr_ctrl  = wr_data & sel_ctrl;
    wire          wr_tbl   = wr_data & sel_tbl;
    wire          wr_ista  = wr_data & sel_ista;
    wire          wr_imsk  = wr_data & sel_imsk;

    // register images
    wire [31:0]   caph_word = {vchl_pkg::CAP_NEXT, vchl_pkg::CAP_VER,
                               vchl_pkg::CAP_ID};
    wire [31:0]   cap1_word = {20'h00000, vchl_pkg::ENTRY_SIZE,
                               vchl_pkg::REF_CLK, 1'b0, lp_cnt_r,
                               1'b0, ext_cnt_r};
    wire [7:0]    arb_cap   = tbl_on ? vchl_pkg::ARB_CAP_ON
                                     : vchl_pkg::ARB_CAP_OFF;
    wire [7:0]    tbl_ofs   = tbl_on ? vchl_pkg::TBL_OFS_ON
                                     : vchl_pkg::TBL_OFS_OFF;
    wire [31:0]   cap2_word = {tbl_ofs, 16'h0000, arb_cap};
    // load bit always reads 0; fields placed by their package positions
    always_comb
    begin
        ctrl_word = 32'h00000000;
        ctrl_word[vchl_pkg::CTRL_SEL_LSB +: 3] = sel_r;
        ctrl_word[vchl_pkg::STAT_TBL_BIT]      = tbl_stat_r;
    end
    wire [31:0]   ista_word = {30'h00000000, irq_stat_r};
    wire [31:0]   imsk_word = {30'h00000000, irq_mask_r};

    wire [31:0]   rd_mux =
        ({32{sel_hdr0}} & hdr_log[31:0])   |
        ({32{sel_hdr1}} & hdr_log[63:32])  |
        ({32{sel_hdr2}} & hdr_log[95:64])  |
        ({32{sel_hdr3}} & hdr_log[127:96]) |
        ({32{sel_caph}} & caph_word)       |
        ({32{sel_cap1}} & cap1_word)       |
        ({32{sel_cap2}} & cap2_word)       |
        ({32{sel_ctrl}} & ctrl_word)       |
        ({32{sel_tbl}}  & tbl_r[tbl_idx])  |
        ({32{sel_ista}} & ista_word)       |
        ({32{sel_imsk}} & imsk_word);

    // out-of-range scheme values fall back to the default scheme
    wire [2:0]    sel_wr = hwdata[vchl_pkg::CTRL_SEL_LSB +: 3];
    wire          sel_ok = sel_wr <= vchl_pkg::SEL_MAX;
    assign sel_nxt = wr_ctrl ? (sel_ok ? sel_wr : vchl_pkg::SEL_RST)
                             : sel_r;
    wire          load_wr = wr_ctrl & hwdata[vchl_pkg::CTRL_LOAD_BIT];

    // a table write in the finishing cycle keeps the status set
    wire          load_fin = load_pend_r & arb_load_done;
    assign load_pend_nxt = load_wr | (load_pend_r & ~arb_load_done);
    assign tbl_stat_nxt  = wr_tbl | (tbl_stat_r & ~load_fin);

    // sticky interrupt bits; a new event beats a clearing write
    assign irq_ev = (2'(hdr_captured) << vchl_pkg::IRQ_HDR_BIT) |
                    (2'(load_fin) << vchl_pkg::IRQ_LOAD_BIT);
    wire [1:0]    irq_w1c = wr_ista ? hwdata[1:0] : 2'b00;
    assign irq_stat_nxt = (irq_stat_r & ~irq_w1c) | irq_ev;
    // registered, so the pin lags the status by one cycle
    wire          irq_hit = |(irq_stat_r & irq_mask_r);

    // strap is sampled once the synchroniser has settled
    wire          strap_take = ~strap_done_r &
                               (strap_cnt_r == vchl_pkg::STRAP_SETTLE);
    wire [1:0]    strap_cnt_nxt = strap_cnt_r + 2'h1;
    assign ext_cnt_nxt = autoload_valid ? autoload_ext_count :
                         strap_take ? {ext_cnt_r[2:1], strap_s2_r} :
                         ext_cnt_r;
    assign lp_cnt_nxt  = autoload_valid ? autoload_lp_count
                                        : lp_cnt_r;

    // reads take one wait state so a preceding write is visible
    always_comb
    begin
        bus_nxt = vchl_pkg::BUS_IDLE;
        unique case (bus_r)
            vchl_pkg::BUS_READ:
                bus_nxt = vchl_pkg::BUS_RDATA;
            vchl_pkg::BUS_IDLE,
            vchl_pkg::BUS_WRITE,
            vchl_pkg::BUS_RDATA:
                if (req)
                begin
                    bus_nxt = hwrite ? vchl_pkg::BUS_WRITE
                                     : vchl_pkg::BUS_READ;
                end
        endcase
    end

    // next values of the bus outputs
    wire          hready_nxt = (bus_nxt != vchl_pkg::BUS_READ);
    wire [31:0]   hrdata_nxt = rd_fill ? rd_mux : 32'h00000000;
    wire          addr_take  = req & (bus_r != vchl_pkg::BUS_READ);

    // bus state and read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_r    <= vchl_pkg::BUS_IDLE;
            addr_r   <= 12'h000;
            hrdata_r <= 32'h00000000;
            hready_r <= 1'b1;
            hresp_r  <= 1'b0;
        end
        else
        begin
            bus_r    <= bus_nxt;
            hresp_r  <= 1'b0;
            if (addr_take)
            begin
                addr_r <= haddr[11:0];
            end
            hready_r <= hready_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // strap synchroniser
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            strap_s1_r   <= 1'b0;
            strap_s2_r   <= 1'b0;
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
        end
        else
        begin
            strap_s1_r <= second_channel_strap;
            strap_s2_r <= strap_s1_r;
            if (!strap_done_r)
            begin
                strap_cnt_r <= strap_cnt_nxt;
            end
            strap_done_r <= strap_done_r | strap_take;
        end
    end

    // capability counts and arbitration control
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_cnt_r   <= vchl_pkg::EXT_CNT_RST;
            lp_cnt_r    <= vchl_pkg::LP_CNT_RST;
            sel_r       <= vchl_pkg::SEL_RST;
            load_r      <= 1'b0;
            load_pend_r <= 1'b0;
            tbl_stat_r  <= 1'b0;
        end
        else
        begin
            ext_cnt_r   <= ext_cnt_nxt;
            lp_cnt_r    <= lp_cnt_nxt;
            sel_r       <= sel_nxt;
            load_r      <= load_wr;
            load_pend_r <= load_pend_nxt;
            tbl_stat_r  <= tbl_stat_nxt;
        end
    end

    // arbitration table storage, one word per eight phases
    genvar w;
    generate
        for (w = 0; w < TW; w = w + 1)
        begin : g_tbl
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    tbl_r[w] <= 32'h00000000;
                end
                else if (wr_tbl && tbl_idx == 2'(w))
                begin
                    tbl_r[w] <= hwdata;
                end
            end
            assign arb_table[32*w +: 32] = tbl_r[w];
        end
    endgenerate

    // interrupt status, mask and output
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_r <= vchl_pkg::IRQ_RST;
            irq_mask_r <= vchl_pkg::IRQ_RST;
            irq_r      <= 1'b0;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_imsk)
            begin
                irq_mask_r <= hwdata[1:0];
            end
            irq_r <= irq_hit;
        end
    end

    vchl_capture u_capture (
        .hclk         (hclk),
        .por_n        (por_n),
        .err_valid    (err_valid),
        .err_masked   (err_masked),
        .err_header   (err_header),
        .hdr_log      (hdr_log),
        .hdr_captured (hdr_captured),
        .err_report   (err_report)
    );

    assign hrdata          = hrdata_r;
    assign hreadyout       = hready_r;
    assign hresp           = hresp_r;
    assign arb_load        = load_r;
    assign arb_scheme      = sel_r;
    assign arb_table_dirty = tbl_stat_r;
    assign irq             = irq_r;

endmodule

/* File: src/vchl_pkg.sv */
// constants and types shared by the channel capability register bank
package vchl_pkg;

    // byte addresses (low 12 bits of haddr)
    localparam logic [11:0] ADDR_HDR0     = 12'h11C;
    localparam logic [11:0] ADDR_HDR1     = 12'h120;
    localparam logic [11:0] ADDR_HDR2     = 12'h124;
    localparam logic [11:0] ADDR_HDR3     = 12'h128;
    localparam logic [11:0] ADDR_CAPHDR   = 12'h140;
    localparam logic [11:0] ADDR_CAP1     = 12'h144;
    localparam logic [11:0] ADDR_CAP2     = 12'h148;
    localparam logic [11:0] ADDR_CTRL     = 12'h14C;
    localparam logic [11:0] ADDR_TBL      = 12'h170;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h180;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h184;

    // capability header fields
    localparam logic [15:0] CAP_ID        = 16'h0002;
    localparam logic [3:0]  CAP_VER       = 4'h1;
    localparam logic [11:0] CAP_NEXT      = 12'h20C;

    // capability one fields
    localparam logic [1:0]  REF_CLK       = 2'h0;
    localparam logic [1:0]  ENTRY_SIZE    = 2'h2;
    localparam logic [2:0]  EXT_CNT_RST   = 3'h0;
    localparam logic [2:0]  LP_CNT_RST    = 3'h0;

    // capability two fields, chosen by the extended count low bit
    localparam logic [7:0]  ARB_CAP_ON    = 8'h03;
    localparam logic [7:0]  ARB_CAP_OFF   = 8'h00;
    localparam logic [7:0]  TBL_OFS_ON    = 8'h03;
    localparam logic [7:0]  TBL_OFS_OFF   = 8'h00;

    // control and status fields
    localparam int          CTRL_LOAD_BIT = 0;
    localparam int          CTRL_SEL_LSB  = 1;
    localparam int          STAT_TBL_BIT  = 16;
    localparam logic [2:0]  SEL_RST       = 3'h0;
    localparam logic [2:0]  SEL_MAX       = 3'h1;

    // arbitration table: 32 phases of 4 bits
    localparam int          TBL_WORDS     = 4;

    // interrupt status and mask layout
    localparam int          IRQ_HDR_BIT   = 0;
    localparam int          IRQ_LOAD_BIT  = 1;
    localparam int          IRQ_W         = 2;
    localparam logic [1:0]  IRQ_RST       = 2'h0;

    // strap settle: cycles after reset release before sampling
    localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ,
        BUS_RDATA
    } vchl_bus_state_type;

endpackage

/* File: src/vchl_capture.sv */
// sticky capture of the logged packet header
`timescale 1ns/100ps
module vchl_capture (
    // clock and power-on reset
    input  wire logic         hclk,
    input  wire logic         por_n,
    // error event from the port logic
    input  wire logic         err_valid,
    input  wire logic         err_masked,
    input  wire logic [127:0] err_header,
    // captured header and reports
    output logic      [127:0] hdr_log,
    output logic              hdr_captured,
    output logic              err_report
);

    logic [127:0] hdr_r;
    logic [127:0] hdr_nxt;
    logic         cap_r;
    logic         rep_r;
    wire          take = err_valid & ~err_masked;

    // byte k of the header arrives in bits 8k+7:8k; byte 4w lands in
    // the top lane of word w
    genvar b;
    generate
        for (b = 0; b < 16; b = b + 1)
        begin : g_byte
            assign hdr_nxt[32*(b/4) + 8*(3-(b%4)) +: 8] =
                err_header[8*b +: 8];
        end
    endgenerate

    // only power-on clears the log, so it survives a port reset
    always_ff @(posedge hclk or negedge por_n)
    begin
        if (!por_n)
        begin
            hdr_r <= '0;
            cap_r <= 1'b0;
            rep_r <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                hdr_r <= hdr_nxt;
            end
            cap_r <= take;
            rep_r <= take;
        end
    end

    assign hdr_log      = hdr_r;
    assign hdr_captured = cap_r;
    assign err_report   = rep_r;

endmodule

/* File: testbench/vchl_regs_props.sv */
// assertions for the channel capability register bank
`timescale 1ns/100ps
module vchl_regs_chk (
    // clock and resets
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        por_n,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // events and arbiter
    input wire logic        err_valid,
    input wire logic        err_masked,
    input wire logic        err_report,
    input wire logic        arb_load,
    input wire logic [2:0]  arb_scheme,
    input wire logic        arb_table_dirty,
    input wire logic        arb_load_done
);
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        wr_r;
    logic        rd_r;
    logic        rd2_r;
    logic [11:0] a_r;
    wire         take = hsel && htrans[1] && hready;
    wire         tbl  = a_r[11:4] == 8'h17;
    wire         ldw  = wr_r && a_r == vchl_pkg::ADDR_CTRL && hwdata[0];
    // a_r holds through the read wait, since no transfer is taken then
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_r  <= 1'b0;
            rd_r  <= 1'b0;
            rd2_r <= 1'b0;
            a_r   <= 12'h000;
        end
        else
        begin
            wr_r  <= take && hwrite;
            rd_r  <= take && !hwrite;
            rd2_r <= rd_r;
            if (take)
                a_r <= haddr[11:0];
        end
    end
    load_pulse_a: assert property (ldw |=> arb_load)
        else $error("load strobe missing");
    load_cause_a: assert property (arb_load |-> $past(ldw) ##1 !arb_load)
        else $error("load strobe without cause");
    dirty_set_a: assert property (wr_r && tbl |=> arb_table_dirty)
        else $error("table status not set");
    dirty_hold_a:
        assert property (arb_table_dirty && !arb_load_done |=> arb_table_dirty)
        else $error("table status cleared early");
    dirty_clr_a:
        assert property ($fell(arb_table_dirty) |-> $past(arb_load_done))
        else $error("table status cleared without load");
    scheme_legal_a: assert property (arb_scheme <= vchl_pkg::SEL_MAX)
        else $error("illegal scheme kept");
    err_log_a:
        assert property (disable iff (!por_n)
            err_valid && !err_masked |=> err_report)
        else $error("error not reported");
    err_mask_a:
        assert property (disable iff (!por_n)
            err_report |-> $past(err_valid && !err_masked))
        else $error("report without unmasked error");
    ctrl_rd_a:
        assert property (rd2_r && a_r == vchl_pkg::ADDR_CTRL
            |-> !hrdata[0] && hrdata[15:4] == 12'h000)
        else $error("control read shows load or reserved bits");
    cover property (arb_load);
    cover property (err_report);
    cover property ($fell(arb_table_dirty));
endmodule
bind vchl_regs vchl_regs_chk u_chk (.hclk, .hresetn, .por_n, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .err_valid,
    .err_masked, .err_report, .arb_load, .arb_scheme, .arb_table_dirty,
    .arb_load_done);

/* File: testbench/tb_vchl_regs.sv */
// self-checking bench for the channel capability register bank
`timescale 1ns/100ps
module tb_vchl_regs;
    logic         hclk = 1'b0;
    logic         hresetn = 1'b0;
    logic         por_n = 1'b0;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [2:0]   hsize = 3'h2;
    logic [31:0]  hwdata = 32'h0;
    wire          hready;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic         second_channel_strap = 1'b1;
    logic         autoload_valid = 1'b0;
    logic [2:0]   autoload_ext_count = 3'h0;
    logic [2:0]   autoload_lp_count = 3'h0;
    logic         err_valid = 1'b0;
    logic         err_masked = 1'b0;
    logic [127:0] err_header = 128'h0;
    logic         err_report;
    logic         arb_load;
    logic [2:0]   arb_scheme;
    logic [127:0] arb_table;
    logic         arb_table_dirty;
    logic         arb_load_done = 1'b0;
    logic         irq;
    logic [31:0]  seed = 32'h43;
    logic [31:0]  rd;
    logic [127:0] hdr_m;
    logic [31:0]  tbl_m [$];
    int           n_errors = 0;
    int           compares = 0;

    assign hready = hreadyout;
    vchl_regs uut (.*);
    always #5 hclk = ~hclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // first header byte of each word lands in the top lane
    function automatic logic [31:0] hw(input int w);
        return {hdr_m[32*w+:8], hdr_m[32*w+8+:8], hdr_m[32*w+16+:8],
                hdr_m[32*w+24+:8]};
    endfunction
    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // bounded wait for hready; a hang ends the run
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 20; n++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                break;
        end
        if (n == 20)
        begin
            n_errors++;
            $display("wrong value at %0t: no ready from the slave", $time);
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic pulse_err(input logic m);
        err_masked <= m;
        err_header <= {rnd(), rnd(), rnd(), rnd()};
        err_valid  <= 1'b1;
        @(posedge hclk);
        err_valid  <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic load(input logic [2:0] e, input logic [2:0] l);
        autoload_ext_count <= e;
        autoload_lp_count  <= l;
        autoload_valid     <= 1'b1;
        @(posedge hclk);
        autoload_valid     <= 1'b0;
    endtask

    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        por_n   <= 1'b1;
        repeat (5) @(posedge hclk);
        rc(vchl_pkg::ADDR_CAPHDR, 32'h20C1_0002);
        rc(vchl_pkg::ADDR_CAP1, 32'h0000_0801);
        rc(vchl_pkg::ADDR_CAP2, 32'h0300_0003);
        rc(vchl_pkg::ADDR_CTRL, 32'h0);
        xfer(vchl_pkg::ADDR_CAP1, 1'b1, 32'hFFFF_FFFF);
        rc(vchl_pkg::ADDR_CAP1, 32'h0000_0801);
        xfer(12'h200, 1'b1, 32'hFFFF_FFFF);
        rc(12'h200, 32'h0);
        pulse_err(1'b0);
        hdr_m = err_header;
        chk({31'h0, err_report}, 32'h1);
        pulse_err(1'b1);
        chk({31'h0, err_report}, 32'h0);
        for (int w = 0; w < 4; w++)
            rc(vchl_pkg::ADDR_HDR0 + 12'(4 * w), hw(w));
        rc(vchl_pkg::ADDR_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        xfer(vchl_pkg::ADDR_IRQ_MASK, 1'b1, 32'h3);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        xfer(vchl_pkg::ADDR_IRQ_STAT, 1'b1, 32'h1);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        for (int w = 0; w < 4; w++)
        begin
            tbl_m.push_back(rnd());
            xfer(vchl_pkg::ADDR_TBL + 12'(4 * w), 1'b1, tbl_m[w]);
        end
        for (int w = 0; w < 4; w++)
        begin
            rc(vchl_pkg::ADDR_TBL + 12'(4 * w), tbl_m[w]);
            chk(arb_table[32*w+:32], tbl_m[w]);
        end
        // a finish strobe with no load pending must be ignored
        arb_load_done <= 1'b1;
        @(posedge hclk);
        arb_load_done <= 1'b0;
        rc(vchl_pkg::ADDR_CTRL, 32'h0001_0000);
        xfer(vchl_pkg::ADDR_CTRL, 1'b1, 32'hFFFF_FFF5);
        rc(vchl_pkg::ADDR_CTRL, 32'h0001_0000);
        chk({29'h0, arb_scheme}, 32'h0);
        arb_load_done <= 1'b1;
        @(posedge hclk);
        arb_load_done <= 1'b0;
        rc(vchl_pkg::ADDR_CTRL, 32'h0);
        rc(vchl_pkg::ADDR_IRQ_STAT, 32'h2);
        chk({31'h0, irq}, 32'h1);
        xfer(vchl_pkg::ADDR_CTRL, 1'b1, 32'h2);
        rc(vchl_pkg::ADDR_CTRL, 32'h2);
        chk({29'h0, arb_scheme}, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        second_channel_strap <= 1'b0;
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
        for (int w = 0; w < 4; w++)
            rc(vchl_pkg::ADDR_HDR0 + 12'(4 * w), hw(w));
        rc(vchl_pkg::ADDR_CAP1, 32'h0000_0800);
        rc(vchl_pkg::ADDR_CAP2, 32'h0);
        rc(vchl_pkg::ADDR_TBL, 32'h0);
        load(3'h6, 3'h5);
        rc(vchl_pkg::ADDR_CAP1, 32'h0000_0856);
        load(3'h7, 3'h0);
        rc(vchl_pkg::ADDR_CAP2, 32'h0300_0003);
        report_and_stop();
    end
endmodule
